// ===== shared/acs_pkg.sv
// package: constants, types and field layout for the converter control block
package acs_pkg;
    // command codes held in the top four bits of each serial word
    localparam logic [3:0] CMD_CHAN_LAST = 4'h7;
    localparam logic [3:0] CMD_POWER_DOWN = 4'h8;
    localparam logic [3:0] CMD_READ_CFG = 4'h9;
    localparam logic [3:0] CMD_WRITE_CFG = 4'ha;
    localparam logic [3:0] CMD_TEST_FIRST = 4'hb;
    localparam logic [3:0] CMD_TEST_LAST = 4'hd;
    localparam logic [3:0] CMD_FIFO_READ = 4'he;
    // configuration word field positions
    localparam int CFG_REF_SEL_BIT = 11;
    localparam int CFG_REF_LVL_BIT = 10;
    localparam int CFG_LONG_SAMP_BIT = 9;
    localparam int CFG_CLK_SEL_LSB = 7;
    localparam int CFG_MODE_LSB = 5;
    localparam int CFG_SEQ_LSB = 3;
    localparam int CFG_PIN_EOC_BIT = 2;
    localparam int CFG_THRESH_LSB = 0;
    localparam logic [11:0] CFG_RESET = 12'h000;
    // sampling and word framing counts, in serial clock edges
    localparam int CMD_BITS = 4;
    localparam int WORD_BITS = 16;
    localparam int HALF_WORD_BITS = 8;
    localparam int SHORT_CONV_EDGE = 16;
    localparam int LONG_CONV_EDGE = 28;
    // least low time on the sample start pin
    localparam int START_LOW_NS = 800;
    localparam int CLK_PERIOD_NS = 40;
    localparam int START_LOW_CYC = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // conversion length in conversion clock ticks
    localparam int CONV_TICKS = 10;
    localparam int OSC_DIV = 2;
    // fifo trigger levels (entries filled)
    localparam logic [3:0] LVL_FULL = 4'h8;
    localparam logic [3:0] LVL_3Q = 4'h6;
    localparam logic [3:0] LVL_HALF = 4'h4;
    localparam logic [3:0] LVL_1Q = 4'h2;

    typedef enum logic [1:0] {MODE_SINGLE, MODE_REPEAT, MODE_SWEEP, MODE_REP_SWEEP} acs_mode_type;
    typedef enum logic [1:0] {CLK_OSC, CLK_SER, CLK_SER4, CLK_SER2} acs_clk_type;

    typedef struct packed {
        logic refInternal;
        logic refTwoVolt;
        logic longSample;
        acs_clk_type clkSel;
        acs_mode_type mode;
        logic [1:0] seqSel;
        logic pinIsEoc;
        logic [1:0] thresh;
    } acs_cfg_type;

    // serial pin group as seen at the device
    typedef struct packed {
        logic chipSelN;
        logic frameSyncIn;
        logic serialClk;
        logic serialInLine;
    } acs_link_type;
endpackage : acs_pkg

// ===== hdl/acs_ctrl.sv
// converter control: configuration word, serial command decode, sampling and fifo
module acs_ctrl
    import acs_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int NUM_CHAN = 8
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire acs_link_type link,
    input wire logic sampleStartPinN,
    input wire logic [9:0] convResult,
    output logic serialOutLine,
    output logic serialOutEn,
    output logic statusPin,
    output logic [2:0] muxSel,
    output logic sampling,
    output logic converting,
    output logic powerDown,
    output logic refInternal,
    output logic refTwoVolt
);
    // elaboration guard: fifo counters and channel maps are sized for these values
    if (FIFO_DEPTH != 8 || (NUM_CHAN != 8 && NUM_CHAN != 4)) begin : g_bad_params
        $error("acs_ctrl: unsupported fifo depth or channel count");
    end

    acs_cfg_type cfg_r;
    logic [15:0] shiftIn_r;
    logic [15:0] shiftOut_r;
    logic [4:0] bitCnt_r;
    logic [5:0] edgeCnt_r;
    logic frameOn_r;
    logic fsMode_r;
    logic sclkQ_r;
    logic fsQ_r;
    logic csQ_r;
    logic startMeta_r;
    logic startSync_r;
    logic startPrev_r;
    logic [3:0] cmd_r;
    logic normSample_r;
    logic [3:0] tickCnt_r;
    logic [1:0] divCnt_r;
    logic [9:0] held_r;
    logic heldValid_r;
    logic [9:0] fifoMem [FIFO_DEPTH];
    logic [3:0] fifoCnt_r;
    logic [2:0] rdPtr_r;
    logic [2:0] seqIdx_r;
    logic irq_r;
    logic sweepDone_r;
    logic [2:0] chan_r;

    // decode of a command nibble as a conversion start
    function automatic logic isConvCmd(input logic [3:0] c);
        return (c <= CMD_CHAN_LAST) || (c >= CMD_TEST_FIRST && c <= CMD_TEST_LAST);
    endfunction : isConvCmd

    // channel of step idx in the chosen sweep order
    function automatic logic [2:0] seqChan(input logic [1:0] s, input logic [2:0] i);
        logic [2:0] c;
        c = 3'h0;
        case (s)
            2'h0: c = i;
            2'h1: c = {i[1:0], 1'b0};
            2'h2: c = {i[2:1], 1'b0};
            default: c = {1'b0, i[0], 1'b0};
        endcase
        // four input parts map the even codes onto their channels
        if (NUM_CHAN == 4)
            c = {1'b0, c[2:1]};
        return c;
    endfunction : seqChan

    // trigger level for the threshold field
    function automatic logic [3:0] level(input logic [1:0] t);
        case (t)
            2'h0: return LVL_FULL;
            2'h1: return LVL_3Q;
            2'h2: return LVL_HALF;
            default: return LVL_1Q;
        endcase
    endfunction : level

    // edge detection on serial pins, sampled as synchronous inputs
    logic sclkRise, sclkFall, capEdge, shiftEdge, csFall, fsFall;
    assign sclkRise = link.serialClk && !sclkQ_r;
    assign sclkFall = !link.serialClk && sclkQ_r;
    assign capEdge = fsMode_r ? sclkFall : sclkRise;
    assign shiftEdge = fsMode_r ? sclkRise : sclkFall;
    assign csFall = !link.chipSelN && csQ_r;
    assign fsFall = !link.frameSyncIn && fsQ_r && !link.chipSelN;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sclkQ_r <= 1'b0;
            fsQ_r <= 1'b1;
            csQ_r <= 1'b1;
        end else begin
            sclkQ_r <= link.serialClk;
            fsQ_r <= link.frameSyncIn;
            csQ_r <= link.chipSelN;
        end
    end

    // start pin two flop synchroniser
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            startMeta_r <= 1'b1;
            startSync_r <= 1'b1;
            startPrev_r <= 1'b1;
        end else begin
            startMeta_r <= sampleStartPinN;
            startSync_r <= startMeta_r;
            startPrev_r <= startSync_r;
        end
    end

    logic startFall, startRise;
    assign startFall = !startSync_r && startPrev_r && link.chipSelN;
    assign startRise = startSync_r && !startPrev_r && link.chipSelN;

    // frame tracking and bit counting; frame sync frames need no cs toggle
    logic frameStart;
    assign frameStart = csFall ? link.frameSyncIn : fsFall;
    logic [4:0] bitNext;
    assign bitNext = bitCnt_r + 5'h1;
    logic wordDone, nibbleDone;
    assign wordDone = frameOn_r && capEdge && bitNext == 5'(WORD_BITS);
    assign nibbleDone = frameOn_r && capEdge && bitNext == 5'(CMD_BITS);
    logic [15:0] wordIn;
    assign wordIn = {shiftIn_r[14:0], link.serialInLine};

    // bit counter holds across a clock pause, so halves may arrive apart
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            frameOn_r <= 1'b0;
            fsMode_r <= 1'b0;
            bitCnt_r <= 5'h0;
            shiftIn_r <= 16'h0000;
        end else if (csFall || fsFall) begin
            frameOn_r <= 1'b1;
            fsMode_r <= csFall ? !link.frameSyncIn : 1'b1;
            bitCnt_r <= 5'h0;
        end else if (link.chipSelN) begin
            frameOn_r <= 1'b0;
        end else if (frameOn_r && capEdge) begin
            shiftIn_r <= wordIn;
            bitCnt_r <= wordDone ? 5'h0 : bitNext;
            if (wordDone)
                frameOn_r <= 1'b0;
        end
    end

    // command latch after the first nibble
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_r <= CMD_POWER_DOWN;
        end else if (nibbleDone) begin
            cmd_r <= wordIn[3:0];
        end
    end

    // configuration word: only a complete write updates it, power down keeps it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= acs_cfg_type'(CFG_RESET);
        end else if (wordDone && cmd_r == CMD_WRITE_CFG) begin
            cfg_r <= acs_cfg_type'(wordIn[11:0]);
        end
    end

    // power down follows the command; any later conversion command wakes it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            powerDown <= 1'b0;
        end else if (nibbleDone) begin
            powerDown <= wordIn[3:0] == CMD_POWER_DOWN;
        end
    end

    // reference controls straight from the configuration
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            refInternal <= 1'b0;
            refTwoVolt <= 1'b0;
        end else begin
            refInternal <= cfg_r.refInternal;
            refTwoVolt <= cfg_r.refTwoVolt;
        end
    end

    // conversion clock tick: serial clock, divided, or free running divider
    logic convTick;
    always_comb begin
        case (cfg_r.clkSel)
            CLK_OSC: convTick = divCnt_r == 2'(OSC_DIV - 1);
            CLK_SER: convTick = sclkRise;
            CLK_SER4: convTick = sclkRise && divCnt_r == 2'h3;
            default: convTick = sclkRise && divCnt_r[0];
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            divCnt_r <= 2'h0;
        end else if (cfg_r.clkSel == CLK_OSC) begin
            divCnt_r <= (divCnt_r == 2'(OSC_DIV - 1)) ? 2'h0 : divCnt_r + 2'h1;
        end else if (sclkRise) begin
            divCnt_r <= divCnt_r + 2'h1;
        end
    end

    // normal sampling window counted in capture edges from frame start
    logic [5:0] convEdge;
    assign convEdge = cfg_r.longSample ? 6'(LONG_CONV_EDGE) : 6'(SHORT_CONV_EDGE);
    logic normConvStart, sampleBegin;
    assign sampleBegin = nibbleDone && isConvCmd(wordIn[3:0]) && !sweepDone_r;
    assign normConvStart = normSample_r && capEdge && edgeCnt_r + 6'h1 == convEdge;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            edgeCnt_r <= 6'h0;
        end else if (frameStart) begin
            edgeCnt_r <= 6'h0;
        end else if (capEdge && edgeCnt_r != 6'h3f) begin
            edgeCnt_r <= edgeCnt_r + 6'h1;
        end
    end

    // sampling state: normal by command, extended by start pin
    logic convStart;
    assign convStart = normConvStart || (sampling && startRise);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sampling <= 1'b0;
            normSample_r <= 1'b0;
        end else if (convStart) begin
            sampling <= 1'b0;
            normSample_r <= 1'b0;
        end else if (sampleBegin) begin
            sampling <= 1'b1;
            normSample_r <= 1'b1;
        end else if (startFall && !sweepDone_r) begin
            sampling <= 1'b1;
            normSample_r <= 1'b0;
        end
    end

    // conversion runs a fixed tick count; a new trigger restarts it
    logic convEnd;
    assign convEnd = converting && convTick && tickCnt_r == 4'(CONV_TICKS - 1);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            converting <= 1'b0;
            tickCnt_r <= 4'h0;
        end else if (convStart) begin
            converting <= 1'b1;
            tickCnt_r <= 4'h0;
        end else if (convEnd) begin
            converting <= 1'b0;
        end else if (converting && convTick) begin
            tickCnt_r <= tickCnt_r + 4'h1;
        end
    end

    // channel choice: command in single and repeat, sequence in sweeps
    logic sweeping;
    assign sweeping = cfg_r.mode == MODE_SWEEP || cfg_r.mode == MODE_REP_SWEEP;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            chan_r <= 3'h0;
        end else if (nibbleDone && wordIn[3:0] <= CMD_CHAN_LAST) begin
            chan_r <= NUM_CHAN == 4 ? {1'b0, wordIn[2:1]} : wordIn[2:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            muxSel <= 3'h0;
        end else begin
            muxSel <= sweeping ? seqChan(cfg_r.seqSel, seqIdx_r) : chan_r;
        end
    end

    // fifo write, threshold compare and overwrite of unread data
    logic useFifo, atLevel, fifoRead, overrun;
    assign useFifo = cfg_r.mode != MODE_SINGLE;
    assign atLevel = fifoCnt_r >= level(cfg_r.thresh);
    assign fifoRead = nibbleDone && wordIn[3:0] == CMD_FIFO_READ;
    assign overrun = irq_r && cfg_r.mode != MODE_SWEEP && (nibbleDone && !fifoRead || startFall);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fifoCnt_r <= 4'h0;
            rdPtr_r <= 3'h0;
        end else if (overrun) begin
            fifoCnt_r <= 4'h0;
            rdPtr_r <= 3'h0;
        end else if (convEnd && useFifo && fifoCnt_r != 4'(FIFO_DEPTH)) begin
            fifoMem[3'(fifoCnt_r)] <= convResult;
            fifoCnt_r <= fifoCnt_r + 4'h1;
        end else if (wordDone && cmd_r == CMD_FIFO_READ && fifoCnt_r != 4'h0) begin
            rdPtr_r <= rdPtr_r + 3'h1;
            if (rdPtr_r + 3'h1 == 3'(fifoCnt_r)) begin
                fifoCnt_r <= 4'h0;
                rdPtr_r <= 3'h0;
            end
        end
    end

    // sweep position; single sweep halts at level or list end until read
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            seqIdx_r <= 3'h0;
            sweepDone_r <= 1'b0;
        end else if (convEnd && sweeping) begin
            // a finishing conversion beats a read in the same cycle
            seqIdx_r <= seqIdx_r + 3'h1;
            if (cfg_r.mode == MODE_SWEEP &&
                    (seqIdx_r == 3'h7 || fifoCnt_r + 4'h1 >= level(cfg_r.thresh)))
                sweepDone_r <= 1'b1;
        end else if (fifoRead || cfg_r.mode != MODE_SWEEP && !sweeping) begin
            seqIdx_r <= 3'h0;
            sweepDone_r <= 1'b0;
        end
    end

    // last conversion result, from a command or the start pin, held for the next read cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            held_r <= 10'h000;
            heldValid_r <= 1'b0;
        end else if (convEnd) begin
            held_r <= convResult;
            heldValid_r <= 1'b1;
        end else if (nibbleDone && (fifoRead || isConvCmd(wordIn[3:0]))) begin
            heldValid_r <= 1'b0;
        end
    end

    // interrupt request: fifo level in fifo modes, end of conversion in single
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else if (useFifo && atLevel) begin
            irq_r <= 1'b1;
        end else if (!useFifo && convEnd) begin
            irq_r <= 1'b1;
        end else if (frameStart) begin
            irq_r <= 1'b0;
        end
    end

    // status pin low active; eoc choice only honoured in single mode
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            statusPin <= 1'b1;
        end else if (cfg_r.pinIsEoc && !useFifo) begin
            statusPin <= !(converting || convStart);
        end else begin
            statusPin <= !irq_r;
        end
    end

    // fifo head first, else the held result while it is still unread
    logic [9:0] outWord;
    assign outWord = fifoCnt_r != 4'h0 ? fifoMem[rdPtr_r] : (heldValid_r ? held_r : 10'h000);

    // output word: readback only when single mode, fifo head or held result
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shiftOut_r <= 16'h0000;
            serialOutLine <= 1'b0;
            serialOutEn <= 1'b0;
        end else if (frameStart) begin
            shiftOut_r <= {outWord, 6'h00};
            serialOutLine <= outWord[9];
            serialOutEn <= 1'b1;
        end else if (link.chipSelN) begin
            serialOutEn <= 1'b0;
        end else if (nibbleDone && wordIn[3:0] == CMD_READ_CFG && cfg_r.mode == MODE_SINGLE) begin
            // three bits already shifted, so d11 leads at the next shift edge
            shiftOut_r <= {1'b0, cfg_r, 3'h0};
        end else if (frameOn_r && shiftEdge) begin
            shiftOut_r <= {shiftOut_r[14:0], 1'b0};
            serialOutLine <= shiftOut_r[14];
        end
    end
endmodule : acs_ctrl

// ===== sim/acs_ctrl_checker.sv
// checker: port timing relations of the converter control block
module acs_ctrl_checker
    import acs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire acs_link_type link,
    input wire logic sampleStartPinN,
    input wire logic [9:0] convResult,
    input wire logic serialOutLine,
    input wire logic serialOutEn,
    input wire logic statusPin,
    input wire logic [2:0] muxSel,
    input wire logic sampling,
    input wire logic converting,
    input wire logic powerDown,
    input wire logic refInternal,
    input wire logic refTwoVolt
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // configuration only moves from a serial write, so power down cannot touch it
    chk_ref_written: assert property ($changed({refInternal, refTwoVolt}) |->
        !$past(link.chipSelN) || !$past(link.chipSelN, 2)) else $error("refs moved outside frame");
    chk_samp_conv_excl: assert property (!(sampling && converting))
        else $error("sampling and converting together");
    chk_conv_after_samp: assert property ($rose(converting) |->
        $past(sampling) || $past(sampling, 2)) else $error("conversion without sampling");
    chk_samp_min_len: assert property ($rose(sampling) |-> sampling [*8])
        else $error("sampling period too short");
    // bench clocks are two core clocks or two sclk periods apart, so ten ticks exceed eight cycles
    chk_conv_min_len: assert property ($rose(converting) |-> converting [*8])
        else $error("conversion too short");
    chk_conv_bounded: assert property ($rose(converting) |-> ##[1:300] !converting)
        else $error("conversion never ended");
    chk_mux_steady: assert property (sampling [*3] |-> $stable(muxSel))
        else $error("channel moved while sampling");
    chk_out_en_cs: assert property (serialOutEn |->
        !$past(link.chipSelN) || !$past(link.chipSelN, 2)) else $error("enable while deselected");
    cover property ($rose(converting));
    cover property ($fell(statusPin));
    cover property ($rose(powerDown));
endmodule : acs_ctrl_checker

bind acs_ctrl acs_ctrl_checker chk_u (.core_clk, .rstn, .link, .sampleStartPinN, .convResult,
    .serialOutLine, .serialOutEn, .statusPin, .muxSel, .sampling, .converting, .powerDown,
    .refInternal, .refTwoVolt);

// ===== sim/acs_host_model.sv
// host serial port model: chip select or frame sync framed words
module acs_host_model
    import acs_pkg::*;
(
    input wire logic core_clk,
    input wire logic serialOutLine,
    output acs_link_type link
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle: deselected, clock still, frame sync high
    initial link = '{1'b1, 1'b1, 1'b0, 1'b0};

    // each serial clock phase is four core clocks, well under the oversampling limit
    task automatic xfer(input logic [15:0] word, input int edges, input int pause,
            input bit useFs, output logic [15:0] rd);
        logic [15:0] sh;
        sh = word;
        rd = 16'h0000;
        @(negedge core_clk);
        if (!useFs) begin
            link.chipSelN <= 1'b1;
            repeat (4) @(negedge core_clk);
        end
        link.chipSelN <= 1'b0;
        link.frameSyncIn <= !useFs;
        link.serialClk <= useFs;
        repeat (4) @(negedge core_clk);
        // frame sync frames begin on its falling edge
        if (useFs) begin
            link.frameSyncIn <= 1'b1;
            repeat (4) @(negedge core_clk);
            link.frameSyncIn <= 1'b0;
            repeat (4) @(negedge core_clk);
        end
        for (int i = 0; i < edges; i++) begin
            if (i == HALF_WORD_BITS) repeat (pause) @(negedge core_clk);
            link.serialInLine <= sh[WORD_BITS-1];
            sh = sh << 1;
            repeat (4) @(negedge core_clk);
            rd = (i < WORD_BITS) ? {rd[14:0], serialOutLine} : rd;
            link.serialClk <= !useFs;
            repeat (4) @(negedge core_clk);
            link.serialClk <= useFs;
        end
        repeat (4) @(negedge core_clk);
        link.chipSelN <= !useFs;
        link.serialInLine <= !link.serialInLine; // released line shows no stale bit
    endtask : xfer
endmodule : acs_host_model

// ===== sim/acs_ctrl_bench.sv
// bench: directed scenarios for the converter control block
`define CHK(what, exp, got) begin nTests++; if ((got) !== (exp)) begin nErrors++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module acs_ctrl_bench
    import acs_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic coreClk;
    logic rstn;
    logic sampleStartPinN;
    logic [9:0] convResult;
    logic serialOutLine, serialOutEn, statusPin, sampling, converting, powerDown;
    logic refInternal, refTwoVolt;
    logic [2:0] muxSel;
    logic [15:0] rdW;
    acs_link_type link;
    acs_cfg_type cfgA, cfgB;
    int nErrors = 0;
    int nTests = 0;
    int nEdge = 0;
    int convEdge = 0;
    bit sawSamp, sawConv;

    acs_ctrl #(.FIFO_DEPTH(8), .NUM_CHAN(8)) dut_u (.core_clk(coreClk), .rstn(rstn),
        .link(link), .sampleStartPinN(sampleStartPinN), .convResult(convResult),
        .serialOutLine(serialOutLine), .serialOutEn(serialOutEn), .statusPin(statusPin),
        .muxSel(muxSel), .sampling(sampling), .converting(converting),
        .powerDown(powerDown), .refInternal(refInternal), .refTwoVolt(refTwoVolt));
    acs_host_model host_u (.core_clk(coreClk), .serialOutLine(serialOutLine), .link(link));

    // capture edges per chip select frame, to place the conversion start
    always @(negedge link.chipSelN) nEdge = 0;
    always @(posedge link.serialClk) nEdge++;
    always @(posedge sampling) sawSamp = 1'b1;
    always @(posedge converting) begin
        convEdge = nEdge;
        sawConv = 1'b1;
    end

    initial begin
        coreClk = 1'b0;
        forever #20 coreClk = !coreClk;
    end

    task automatic endOfTest();
        $display("comparisons %0d, mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : endOfTest

    task automatic send(input logic [15:0] w, input int e = 16, input bit fs = 1'b0);
        host_u.xfer(w, e, 0, fs, rdW);
    endtask : send

    // bounded wait, then two cycles so registered status lands; keeps triggers apart
    task automatic waitIdle();
        int k;
        for (k = 0; k < 400 && (converting !== 1'b0 || sampling !== 1'b0); k++) begin
            @(negedge coreClk);
        end
        if (k == 400) begin
            nErrors++;
            endOfTest();
        end
        repeat (2) @(negedge coreClk);
    endtask : waitIdle

    task automatic cfgCheck();
        `CHK("reset", 5'b10000, {statusPin, serialOutEn, refInternal, converting, powerDown})
        send({CMD_WRITE_CFG, 12'h000});
        host_u.xfer({CMD_WRITE_CFG, cfgA}, 16, 60, 1'b0, rdW);
        `CHK("refs", 2'b11, {refInternal, refTwoVolt})
        sawSamp = 1'b0;
        send({CMD_READ_CFG, 12'h000});
        `CHK("cfg readback", cfgA, rdW[11:0])
        `CHK("read sampled", 1'b0, sawSamp)
    endtask : cfgCheck

    // every nibble but power down; only selects and tests may sample
    task automatic cmdSweep();
        logic [3:0] c;
        logic [11:0] d;
        bit e;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            d = (c == CMD_WRITE_CFG) ? cfgA : 12'h000;
            e = c <= CMD_CHAN_LAST || (c >= CMD_TEST_FIRST && c <= CMD_TEST_LAST);
            if (c != CMD_POWER_DOWN) begin
                sawSamp = 1'b0;
                send({c, d});
                waitIdle();
                `CHK("cmd sampled", e, sawSamp)
            end
        end
    endtask : cmdSweep

    task automatic convTiming();
        send({4'h3, 12'h000});
        `CHK("mux", 3'h3, muxSel)
        `CHK("out enable", 1'b1, serialOutEn)
        `CHK("short edge", SHORT_CONV_EDGE, convEdge)
        `CHK("eoc busy", 2'b10, {converting, statusPin})
        waitIdle();
        `CHK("eoc done", 1'b1, statusPin)
        cfgB = '{1'b1, 1'b1, 1'b1, CLK_OSC, MODE_SINGLE, 2'h0, 1'b1, 2'h0};
        send({CMD_WRITE_CFG, cfgB});
        send({4'h5, 12'h000}, LONG_CONV_EDGE);
        `CHK("long edge", LONG_CONV_EDGE, convEdge)
        waitIdle();
        // sclk halves as conversion clock: ten ticks need twenty more rises
        cfgB.longSample = 1'b0;
        cfgB.clkSel = CLK_SER2;
        send({CMD_WRITE_CFG, cfgB});
        sawConv = 1'b0;
        send({4'h2, 12'h000}, SHORT_CONV_EDGE + 2 * CONV_TICKS);
        `CHK("sclk conversion", 2'b10, {sawConv, converting})
        send({CMD_WRITE_CFG, cfgA});
    endtask : convTiming

    // start pin held past its least low time; result shown on the next frame
    task automatic extSample();
        int k;
        convResult = 10'h2c5;
        sampleStartPinN = 1'b0;
        repeat (START_LOW_CYC + 4) @(negedge coreClk);
        `CHK("ext sampling", 2'b10, {sampling, converting})
        sampleStartPinN = 1'b1;
        for (k = 0; k < 10 && converting !== 1'b1; k++) @(negedge coreClk);
        `CHK("ext converting", 1'b1, converting)
        waitIdle();
        convResult = 10'h13a;
        send({4'h1, 12'h000});
        `CHK("ext result", 10'h2c5, rdW[15:6])
        waitIdle();
    endtask : extSample

    task automatic repeatIrq();
        cfgB = '{1'b1, 1'b1, 1'b0, CLK_OSC, MODE_REPEAT, 2'h0, 1'b0, 2'h3};
        send({CMD_WRITE_CFG, cfgB});
        for (int i = 1; i <= LVL_1Q; i++) begin
            send({4'h1, 12'h000});
            waitIdle();
            `CHK("repeat irq", i < LVL_1Q, statusPin)
        end
        send({CMD_FIFO_READ, 12'h000});
        `CHK("repeat data", 10'h13a, rdW[15:6])
    endtask : repeatIrq

    // frame sync triggers throughout, chip select held low after the configuration write
    task automatic sweepSeq();
        logic [2:0] seqExp [4] = '{3'h0, 3'h2, 3'h0, 3'h2};
        cfgB = '{1'b1, 1'b1, 1'b0, CLK_OSC, MODE_SWEEP, 2'h3, 1'b0, 2'h2};
        // new value: stale repeat entries must have been dropped
        convResult = 10'h0f1;
        send({CMD_WRITE_CFG, cfgB});
        for (int i = 0; i < 4; i++) begin
            send({4'h0, 12'h000}, 16, 1'b1);
            `CHK("sweep mux", seqExp[i], muxSel)
            waitIdle();
        end
        `CHK("sweep irq", 1'b0, statusPin)
        sawConv = 1'b0;
        send({4'h0, 12'h000}, 16, 1'b1);
        waitIdle();
        `CHK("sweep held", 1'b0, sawConv)
        send({CMD_FIFO_READ, 12'h000}, 16, 1'b1);
        `CHK("sweep data", 10'h0f1, rdW[15:6])
    endtask : sweepSeq

    initial begin
        rstn = 1'b0;
        sampleStartPinN = 1'b1;
        convResult = 10'h000;
        cfgA = '{1'b1, 1'b1, 1'b0, CLK_OSC, MODE_SINGLE, 2'h0, 1'b1, 2'h0};
        repeat (6) @(negedge coreClk);
        rstn = 1'b1;
        repeat (2) @(negedge coreClk);
        cfgCheck();
        cmdSweep();
        convTiming();
        extSample();
        repeatIrq();
        sweepSeq();
        send({CMD_POWER_DOWN, 12'h000});
        `CHK("power down", 3'b111, {powerDown, refInternal, refTwoVolt})
        endOfTest();
    end
endmodule : acs_ctrl_bench
